// file: nco_consts.svh
// Constants for the oscillator tuning configuration block.
// Assumes inclusion by bare name from the package and the tuning configuration module.
// Overview of operation
// R1: One shared 16-bit read/write rational step divisor serves all eight presets.
// R2: Software programs divisor as sample rate over frequency step, divided by 128.
// R3: Software keeps the divisor at or below 8192 to protect spur performance.
// R4: Software uses only rate and step pairs giving an integer divisor.
// R5: Output frequency equals tuning word times two to minus 32 times sample rate.
// R6: Tuning word behaves identically whether read as signed or unsigned, modulo sample rate.
// R7: Tuning word write while output link runs makes phase non-deterministic.
// R8: Controller re-initializes the output link after tuning changes for deterministic phase.
// R9: With non-integer word, software programs divisor and rounds the scaled word.
// R10: Each preset has its own 16-bit phase offset, both bytes reset to zero.
// R11: Phase offset sits in upper half of 32 bits, added to accumulator.
// R12: Active preset comes from pins when source bit is 0, else register field.
// R13: Accumulator advances by the active word each sample, wrapping per divisor ratio.
`ifndef NCO_CONSTS_SVH
`define NCO_CONSTS_SVH

// ****************************************************************
// Register word addresses
// ****************************************************************
`define NCO_ADDR_W 8
`define NCO_ADDR_RDIV 8'h00
`define NCO_ADDR_MODE 8'h01
`define NCO_ADDR_SEL 8'h02
`define NCO_ADDR_STATUS 8'h03
`define NCO_ADDR_RNUM 8'h04
`define NCO_BANK_FREQ 5'h01
`define NCO_BANK_PHASE 5'h02

// ****************************************************************
// Field layout and reset values
// ****************************************************************
`define NCO_WORD_RESET 32'hc0000000
`define NCO_OFFSET_RESET 16'h0000
`define NCO_DIVISOR_RESET 16'h0000
`define NCO_RNUM_RESET 16'h0000
`define NCO_SELECT_RESET 3'h0
`define NCO_SOURCE_RESET 1'b0
`define NCO_STAT_NONDET 0
`define NCO_STAT_LINK 4
`define NCO_OFFSET_SHIFT 16
`define NCO_PRESETS 8

`endif

// file: nco_pkg.sv
// Types shared by the oscillator tuning configuration modules.
// Assumes the constants header is on the include path.
`include "nco_consts.svh"

package nco_pkg;
  typedef logic [2:0] nco_preset_t;
  typedef logic [31:0] nco_word_t;
  typedef logic [15:0] nco_half_t;
  typedef logic [`NCO_ADDR_W-1:0] nco_addr_t;
endpackage

// file: nco_sample_div.sv
// Sample-rate enable divider: one-cycle pulse every DIV clocks.
// Assumes a single clock with synchronous active-low reset.
`timescale 1ns/1ps

module nco_sample_div #(
  parameter int DIV = 1
) (
  input wire logic clock,
  input wire logic rst_b,
  output logic sample_en
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  wire at_last = (cnt_r == LAST);

  assign cnt_nxt = at_last ? '0 : cnt_r + CW'(1);
  assign sample_en = at_last;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule

// file: nco_phase_acc.sv
// Phase accumulator with rational correction of the per-sample increment.
// Assumes numerator below divisor; divisor of zero disables the correction.
`timescale 1ns/1ps

module nco_phase_acc (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic sample_en,
  input wire nco_pkg::nco_word_t step_word,
  input wire nco_pkg::nco_half_t rdiv,
  input wire nco_pkg::nco_half_t rnum,
  output nco_pkg::nco_word_t acc
);
  nco_pkg::nco_word_t acc_r;
  nco_pkg::nco_word_t acc_nxt;
  logic [15:0] res_r;
  logic [15:0] res_nxt;
  logic [16:0] res_sum;
  logic carry;
  wire rational_on = (rdiv != 16'h0000);

  // Increment is word plus rnum/rdiv, so the wrap tracks the step ratio exactly
  assign res_sum = {1'b0, res_r} + {1'b0, rnum};
  assign carry = rational_on && (res_sum >= {1'b0, rdiv}); // R13
  assign res_nxt = !rational_on ? 16'h0000 :
                   carry ? 16'(res_sum - {1'b0, rdiv}) : res_sum[15:0];
  // Modulo 2^32 add makes signed and unsigned words alias alike
  assign acc_nxt = acc_r + step_word + {31'h0, carry}; // R5 R6 R13
  assign acc = acc_r;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      acc_r <= '0;
      res_r <= '0;
    end else if (sample_en) begin
      acc_r <= acc_nxt;
      res_r <= res_nxt;
    end
  end
endmodule

// file: nco_tuning_config.sv
// Tuning configuration for the down-converter oscillator: register file,
// preset selection, phase accumulation and phase-determinism tracking.
// Assumes a plain register port with read data one cycle after the strobe.
`timescale 1ns/1ps
`include "nco_consts.svh"

module nco_tuning_config #(
  parameter int SAMPLE_DIV = 1
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire nco_pkg::nco_addr_t reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire nco_pkg::nco_preset_t preset_select_pins,
  input wire logic link_running,
  input wire logic link_reinit,
  output nco_pkg::nco_word_t phase_out,
  output nco_pkg::nco_word_t active_tuning_word,
  output nco_pkg::nco_preset_t active_preset,
  output logic phase_nondet
);
  // ****************************************************************
  // Storage
  // ****************************************************************
  nco_pkg::nco_half_t rational_step_divisor_r;
  nco_pkg::nco_half_t rational_numerator_r;
  nco_pkg::nco_word_t preset_tuning_word_r [`NCO_PRESETS];
  nco_pkg::nco_half_t preset_phase_offset_r [`NCO_PRESETS];
  logic preset_source_mode_r;
  nco_pkg::nco_preset_t preset_select_field_r;
  logic nondet_r;
  logic nondet_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  nco_pkg::nco_word_t phase_r;
  nco_pkg::nco_word_t word_r;
  nco_pkg::nco_preset_t preset_r;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function automatic logic in_bank(input nco_pkg::nco_addr_t a, input logic [4:0] bank);
    in_bank = (a[`NCO_ADDR_W-1:3] == bank);
  endfunction

  wire nco_pkg::nco_preset_t idx = reg_addr[2:0];
  wire hit_rdiv = (reg_addr == `NCO_ADDR_RDIV);
  wire hit_mode = (reg_addr == `NCO_ADDR_MODE);
  wire hit_sel = (reg_addr == `NCO_ADDR_SEL);
  wire hit_stat = (reg_addr == `NCO_ADDR_STATUS);
  wire hit_rnum = (reg_addr == `NCO_ADDR_RNUM);
  wire hit_freq = in_bank(reg_addr, `NCO_BANK_FREQ);
  wire hit_phase = in_bank(reg_addr, `NCO_BANK_PHASE);
  wire wr_freq = reg_wr && hit_freq;
  wire wr_phase = reg_wr && hit_phase;

  // ****************************************************************
  // Preset selection
  // ****************************************************************
  wire nco_pkg::nco_preset_t sel_now =
    preset_source_mode_r ? preset_select_field_r : preset_select_pins; // R12
  wire nco_pkg::nco_word_t word_now = preset_tuning_word_r[sel_now];
  wire nco_pkg::nco_half_t offs_now = preset_phase_offset_r[sel_now];

  // ****************************************************************
  // Phase accumulation
  // ****************************************************************
  logic sample_en;
  nco_pkg::nco_word_t acc;

  nco_sample_div #(
    .DIV(SAMPLE_DIV)
  ) u_div (
    .clock(clock),
    .rst_b(rst_b),
    .sample_en(sample_en)
  );

  nco_phase_acc u_acc (
    .clock(clock),
    .rst_b(rst_b),
    .sample_en(sample_en),
    .step_word(word_now),
    .rdiv(rational_step_divisor_r), // R1
    .rnum(rational_numerator_r),
    .acc(acc)
  );

  // Offset is MSB-justified: one step is 2*pi/65536 radians
  wire nco_pkg::nco_word_t phase_nxt = acc + {offs_now, 16'h0000}; // R11

  // ****************************************************************
  // Determinism tracking
  // ****************************************************************
  // A new word changes phase against link alignment; a fresh link start
  // restores it. A write in the clearing cycle still sets the flag.
  wire nondet_set = wr_freq && link_running; // R7
  wire nondet_clr = link_reinit ||
    (reg_wr && hit_stat && reg_wdata[`NCO_STAT_NONDET]); // R8
  assign nondet_nxt = nondet_set | (nondet_r & ~nondet_clr);

  // ****************************************************************
  // Read mux
  // ****************************************************************
  wire [31:0] status_word = {27'h0, link_running, sel_now, nondet_r};
  assign rdata_nxt = !reg_rd ? 32'h0 :
                     hit_rdiv ? {16'h0, rational_step_divisor_r} :
                     hit_mode ? {31'h0, preset_source_mode_r} :
                     hit_sel ? {29'h0, preset_select_field_r} :
                     hit_stat ? status_word :
                     hit_rnum ? {16'h0, rational_numerator_r} :
                     hit_freq ? preset_tuning_word_r[idx] :
                     hit_phase ? {16'h0, preset_phase_offset_r[idx]} :
                     32'h0;

  // ****************************************************************
  // Register writes
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      rational_step_divisor_r <= `NCO_DIVISOR_RESET;
      rational_numerator_r <= `NCO_RNUM_RESET;
      preset_source_mode_r <= `NCO_SOURCE_RESET;
      preset_select_field_r <= `NCO_SELECT_RESET;
    end else if (reg_wr) begin
      if (hit_rdiv) begin
        rational_step_divisor_r <= reg_wdata[15:0]; // R1
      end
      if (hit_rnum) begin
        rational_numerator_r <= reg_wdata[15:0];
      end
      if (hit_mode) begin
        preset_source_mode_r <= reg_wdata[0]; // R12
      end
      if (hit_sel) begin
        preset_select_field_r <= reg_wdata[2:0]; // R12
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      for (int i = 0; i < `NCO_PRESETS; i++) begin
        preset_tuning_word_r[i] <= `NCO_WORD_RESET;
        preset_phase_offset_r[i] <= `NCO_OFFSET_RESET; // R10
      end
    end else begin
      if (wr_freq) begin
        preset_tuning_word_r[idx] <= reg_wdata; // R5
      end
      if (wr_phase) begin
        preset_phase_offset_r[idx] <= reg_wdata[15:0]; // R10
      end
    end
  end

  // ****************************************************************
  // Output registers
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      nondet_r <= 1'b0;
      rdata_r <= 32'h0;
      phase_r <= 32'h0;
      word_r <= `NCO_WORD_RESET;
      preset_r <= `NCO_SELECT_RESET;
    end else begin
      nondet_r <= nondet_nxt;
      rdata_r <= rdata_nxt;
      phase_r <= phase_nxt;
      word_r <= word_now;
      preset_r <= sel_now;
    end
  end

  assign reg_rdata = rdata_r;
  assign phase_out = phase_r;
  assign active_tuning_word = word_r;
  assign active_preset = preset_r;
  assign phase_nondet = nondet_r;
endmodule

// file: nco_tuning_config_checker.sv
// Port-level assertions for the oscillator tuning block.
// Assumes a bind to the top module; sees only its ports.
`timescale 1ns/1ps
module nco_tuning_config_checker #(
  parameter int SAMPLE_DIV = 1
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire nco_pkg::nco_addr_t reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire nco_pkg::nco_preset_t preset_select_pins,
  input wire logic link_running,
  input wire logic link_reinit,
  input wire nco_pkg::nco_word_t phase_out,
  input wire nco_pkg::nco_word_t active_tuning_word,
  input wire nco_pkg::nco_preset_t active_preset,
  input wire logic phase_nondet
);
  // ************************************
  // Properties
  // ************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  sequence s_word_wr;
    reg_wr && reg_addr[7:3] == 5'h01;
  endsequence
  sequence s_phase_wr;
    reg_wr && reg_addr[7:3] == 5'h02;
  endsequence
  sequence s_rd_back;
    reg_rd && reg_addr == $past(reg_addr);
  endsequence
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside read cycle");
  a_word_readback: assert property (
    s_word_wr ##1 s_rd_back |=> reg_rdata == $past(reg_wdata, 2))
    else $error("tuning word readback differs");
  a_phase_readback: assert property (
    s_phase_wr ##1 s_rd_back |=> reg_rdata == ($past(reg_wdata, 2) & 32'h0000ffff))
    else $error("phase offset readback differs");
  a_unmapped_read: assert property (reg_rd && reg_addr > 8'h17 |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_nondet_set: assert property (s_word_wr and link_running |=> phase_nondet)
    else $error("flag not set by word write while link runs");
  a_reinit_clear: assert property (link_reinit && !reg_wr |=> !phase_nondet)
    else $error("flag not cleared by link reinit");
  a_w1c_clear: assert property (
    reg_wr && reg_addr == 8'h03 && reg_wdata[0] && !link_reinit |=> !phase_nondet)
    else $error("flag not cleared by status write");
  a_word_hold: assert property (
    $stable(active_preset) && !$past(reg_wr, 2) |-> $stable(active_tuning_word))
    else $error("active word changed without cause");
endmodule

// file: tb_nco_tuning_config.sv
// Self-checking bench for the oscillator tuning block.
// Assumes the package, header and design files compile first.
`timescale 1ns/1ps
module tb_nco_tuning_config;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  nco_pkg::nco_addr_t reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  nco_pkg::nco_preset_t pins = 3'h0;
  logic link_running = 1'b0;
  logic link_reinit = 1'b0;
  nco_pkg::nco_word_t phase_out;
  nco_pkg::nco_word_t active_tuning_word;
  nco_pkg::nco_preset_t active_preset;
  logic phase_nondet;
  int error_cnt = 0;
  int checks_done = 0;
  logic [31:0] words [8];
  logic [15:0] phs [8];
  logic [31:0] x0;
  nco_tuning_config #(.SAMPLE_DIV(1)) dut (.clock(clock), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .preset_select_pins(pins), .link_running(link_running),
    .link_reinit(link_reinit), .phase_out(phase_out),
    .active_tuning_word(active_tuning_word), .active_preset(active_preset),
    .phase_nondet(phase_nondet));
  initial begin
    forever #2.5 clock = ~clock;
  end
  // ************************************
  // Tasks
  // ************************************
  function automatic logic [31:0] model(logic [7:0] a);
    if (a[7:3] == 5'h01) return words[a[2:0]];
    if (a[7:3] == 5'h02) return {16'h0, phs[a[2:0]]};
    return 32'h0;
  endfunction
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  // Write and read of one address with no idle cycle between the strobes
  task automatic wr_rd(logic [7:0] a, logic [31:0] d, logic [31:0] exp);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    chk("write then read", reg_rdata, exp);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] exp);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    chk("reg read", reg_rdata, exp);
  endtask
  task automatic settle(int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    final_report();
  end
  initial begin
    x0 = $urandom(25372);
    for (int i = 0; i < 8; i++) begin
      words[i] = 32'hc0000000;
      phs[i] = 16'h0;
    end
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    for (int a = 0; a < 24; a++) rd(8'(a), model(8'(a)));
    chk("reset word", active_tuning_word, 32'hc0000000);
    $display("end test reset");
    for (int i = 0; i < 8; i++) begin
      words[i] = (i == 0) ? 32'h80000000 : $urandom;
      phs[i] = 16'($urandom);
      wr_rd(8'h08 + 8'(i), words[i], words[i]);
      wr_rd(8'h10 + 8'(i), {16'($urandom), phs[i]}, {16'h0, phs[i]});
    end
    wr(8'h00, 32'hffff2000);
    rd(8'h00, 32'h00002000);
    for (int a = 8; a < 24; a++) rd(8'(a), model(8'(a)));
    for (int a = 5; a < 8; a++) begin
      wr(8'(a * 40), $urandom);
      rd(8'(a * 40), 32'h0);
    end
    $display("end test registers");
    // Pins first, then the field while the pins wander
    for (int m = 0; m < 2; m++) begin
      wr(8'h01, 32'(m));
      for (int p = 0; p < 8; p++) begin
        if (m == 1) wr(8'h02, 32'(p));
        @(posedge clock);
        pins <= (m == 1) ? 3'($urandom) : 3'(p);
        settle(3);
        chk("preset", {29'h0, active_preset}, 32'(p));
        chk("word", active_tuning_word, words[p]);
      end
    end
    $display("end test presets");
    wr(8'h02, 32'h3);
    wr(8'h00, 32'h0);
    wr(8'h13, 32'h0);
    settle(3);
    x0 = phase_out;
    wr(8'h13, 32'h00001234);
    settle(3);
    chk("phase", phase_out, x0 + 5 * words[3] + 32'h12340000);
    wr(8'h04, 32'h2);
    wr(8'h00, 32'h5);
    settle(3);
    x0 = phase_out;
    // Ten samples span two full residue periods, so exactly four carries
    settle(10);
    chk("rational", phase_out, x0 + 10 * words[3] + 32'h4);
    $display("end test accumulator");
    wr(8'h08, words[0]);
    settle(1);
    chk("nondet idle", 32'(phase_nondet), 32'h0);
    @(posedge clock);
    link_running <= 1'b1;
    wr(8'h09, words[1]);
    settle(1);
    chk("nondet set", 32'(phase_nondet), 32'h1);
    rd(8'h03, 32'h00000017);
    @(posedge clock);
    link_reinit <= 1'b1;
    @(posedge clock);
    link_reinit <= 1'b0;
    settle(1);
    chk("reinit", 32'(phase_nondet), 32'h0);
    wr(8'h0a, words[2]);
    wr(8'h03, 32'h1);
    settle(1);
    chk("w1c", 32'(phase_nondet), 32'h0);
    // Word write in the same cycle as a link restart: the set must win
    @(posedge clock);
    link_reinit <= 1'b1;
    wr(8'h0b, words[3]);
    link_reinit <= 1'b0;
    settle(1);
    chk("set wins", 32'(phase_nondet), 32'h1);
    $display("end test determinism");
    final_report();
  end
endmodule
bind nco_tuning_config nco_tuning_config_checker #(.SAMPLE_DIV(SAMPLE_DIV)) u_chk (
  .clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .preset_select_pins(preset_select_pins), .link_running(link_running),
  .link_reinit(link_reinit), .phase_out(phase_out),
  .active_tuning_word(active_tuning_word), .active_preset(active_preset),
  .phase_nondet(phase_nondet));
